// ===== hw/uffc_unknown_frame_forward_ctrl.sv
// Purpose: Global forwarding policy for lookup-miss frames,
//          self-address egress filter, drive strength select
// Assumes: One 50 MHz core clock, synchronous active-high reset
// Notes:   Lookup engines and self MAC storage sit outside
//          Strap loads three edges after reset release for a high pin
//          and four for a low one, as the third stage starts at 1
//          Software should leave the drive field alone until then
//          Fixed bits of each byte are not stored; writes to them vanish
//
// Behaviour
// - With unknown-unicast enable set, unicast lookup misses follow the unknown-unicast port map.
// - The unicast port map has one bit per port from port 1 up, zero filters and all ones floods.
// - With unknown-multicast enable set, non-IP multicast misses follow the unknown-multicast map.
// - The multicast port map has one bit per port, zero filters and all ones floods all five ports.
// - With unknown-VID enable set, frames with a VLAN ID missing from the table follow the VID map.
// - The VID port map has one bit per port, zero drops and all ones sends to every port.
// - With unknown-IP-multicast enable set, IP multicast misses follow the IP multicast map.
// - The IP multicast port map has one bit per port, zero filters and all ones floods.
// - With self-address filter enable set, frames carrying the switch's own MAC are discarded.
// - Self-address filtering is done at egress against the switch MAC from the address registers.
// - Drive code 00 is 4 mA, 01 is 8 mA, 10 is 12 mA, 11 is 16 mA, and it goes to the I/O drivers.
// - After reset the drive code loads from the pulled-up strap, upper bit inverted, lower bit as is.

`include "uffc_defs.svh"

module uffc_unknown_frame_forward_ctrl
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Management register port
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_rd_in,
  output logic      [7:0]           reg_rdata_out,
  output logic                      reg_rvalid_out,
  // Lookup-miss forwarding decision
  input  wire logic                 miss_valid_in,
  input  wire uffc_pkg::uffc_class_type miss_class_in,
  input  wire logic [4:0]           miss_default_map_in,
  output logic                      fwd_valid_out,
  output logic      [4:0]           fwd_map_out,
  output logic                      fwd_override_out,
  // Egress self-address check
  input  wire logic                 egress_valid_in,
  input  wire logic [47:0]          egress_mac_in,
  input  wire logic [47:0]          self_mac_in,
  output logic                      egress_valid_out,
  output logic                      egress_drop_out,
  // Pad drive strength
  input  wire logic                 drive_strength_strap_pin_in,
  output logic      [1:0]           drive_strength_out
);

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  // Disabled class falls back to the lookup default
  function automatic logic [4:0] pick_map
  (
    input logic       en,
    input logic [4:0] map,
    input logic [4:0] dflt
  );
    pick_map = en ? map : dflt;
  endfunction

  // One place decides which offset a write strobe hits
  function automatic logic ofs_hit
  (
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    ofs_hit = (addr == ofs);
  endfunction

  // Pull-up alone gives 8 mA, a pull-down 12 mA
  function automatic logic [1:0] strap_code
  (
    input logic level
  );
    strap_code = {~level, level};
  endfunction

  function automatic logic [7:0] ctrl_byte
  (
    input logic [1:0] top,
    input logic       en,
    input logic [4:0] map
  );
    ctrl_byte = {top, en, map};
  endfunction

  // ---------------------------------------------------------
  // State
  // ---------------------------------------------------------
  uffc_pkg::uffc_state_type state;
  uffc_pkg::uffc_state_type next_state;

  logic wr_ucast;
  logic wr_drv_mcast;
  logic wr_vlan;
  logic wr_self_ipmc;
  logic strap_agree;
  logic self_hit;

  // Strobes come from same-clock logic, so no synchroniser
  assign wr_ucast     = reg_wr_in && ofs_hit(reg_addr_in, `UFFC_OFS_UCAST);
  assign wr_drv_mcast = reg_wr_in && ofs_hit(reg_addr_in, `UFFC_OFS_DRV_MCAST);
  assign wr_vlan      = reg_wr_in && ofs_hit(reg_addr_in, `UFFC_OFS_VLAN);
  assign wr_self_ipmc = reg_wr_in && ofs_hit(reg_addr_in, `UFFC_OFS_SELF_IPMC);
  // Second and third stages only; first stage feeds nothing else
  // Two samples must agree so a slow strap edge is not taken half way
  assign strap_agree  = (state.strap_sync[1] == state.strap_sync[2]);
  assign self_hit     = (egress_mac_in == self_mac_in);

  // ---------------------------------------------------------
  // Next state
  // ---------------------------------------------------------
  always_comb
  begin
    next_state = state;

    // -------------------------------------------------------
    // Register writes
    // -------------------------------------------------------
    if (wr_ucast)
    begin
      next_state.ucast_en  = reg_wdata_in[`UFFC_EN_BIT];
      next_state.ucast_map = reg_wdata_in[`UFFC_MAP_MSB:0];
    end
    if (wr_drv_mcast)
    begin
      next_state.drive     = reg_wdata_in[`UFFC_DRV_MSB:`UFFC_DRV_LSB];
      next_state.mcast_en  = reg_wdata_in[`UFFC_EN_BIT];
      next_state.mcast_map = reg_wdata_in[`UFFC_MAP_MSB:0];
    end
    if (wr_vlan)
    begin
      next_state.vlan_en   = reg_wdata_in[`UFFC_EN_BIT];
      next_state.vlan_map  = reg_wdata_in[`UFFC_MAP_MSB:0];
    end
    if (wr_self_ipmc)
    begin
      next_state.self_en   = reg_wdata_in[`UFFC_SELF_BIT];
      next_state.ipmc_en   = reg_wdata_in[`UFFC_EN_BIT];
      next_state.ipmc_map  = reg_wdata_in[`UFFC_MAP_MSB:0];
    end

    // -------------------------------------------------------
    // Register reads, one cycle latency
    // -------------------------------------------------------
    // Read and write of one offset together return the old byte
    next_state.rvalid = reg_rd_in;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `UFFC_OFS_UCAST:
          next_state.rdata = ctrl_byte({`UFFC_UCAST_B7_VAL, 1'b0},
                                       state.ucast_en, state.ucast_map);
        `UFFC_OFS_DRV_MCAST:
          next_state.rdata = ctrl_byte(state.drive, state.mcast_en,
                                       state.mcast_map);
        `UFFC_OFS_VLAN:
          next_state.rdata = ctrl_byte(2'h0, state.vlan_en,
                                       state.vlan_map);
        `UFFC_OFS_SELF_IPMC:
          next_state.rdata = ctrl_byte({1'b0, state.self_en},
                                       state.ipmc_en, state.ipmc_map);
        default:
          next_state.rdata = `UFFC_RD_NONE;
      endcase
    end

    // -------------------------------------------------------
    // Strap synchroniser, runs from reset release
    // -------------------------------------------------------
    next_state.strap_sync = {state.strap_sync[1:0],
                             drive_strength_strap_pin_in};

    // -------------------------------------------------------
    // Strap capture once stages two and three agree
    // -------------------------------------------------------
    case (state.strap_state)
      uffc_pkg::UFFC_ST_WAIT1:
        next_state.strap_state = uffc_pkg::UFFC_ST_WAIT2;
      uffc_pkg::UFFC_ST_WAIT2:
        next_state.strap_state = uffc_pkg::UFFC_ST_WAIT3;
      uffc_pkg::UFFC_ST_WAIT3:
      begin
        // A software write in this cycle would be overwritten,
        // so the strap is taken only when it is stable
        if (strap_agree)
        begin
          next_state.drive = strap_code(state.strap_sync[2]);
          next_state.strap_state = uffc_pkg::UFFC_ST_RUN;
        end
      end
      uffc_pkg::UFFC_ST_RUN:
        next_state.strap_state = uffc_pkg::UFFC_ST_RUN;
      default:
        next_state.strap_state = uffc_pkg::UFFC_ST_WAIT1;
    endcase

    // -------------------------------------------------------
    // Lookup-miss forwarding decision
    // -------------------------------------------------------
    // Map and override hold between requests; only valid pulses
    next_state.fwd_valid    = miss_valid_in;
    next_state.fwd_map      = state.fwd_map;
    next_state.fwd_override = state.fwd_override;
    if (miss_valid_in)
    begin
      case (miss_class_in)
        uffc_pkg::UFFC_CLS_UCAST:
        begin
          next_state.fwd_map = pick_map(state.ucast_en, state.ucast_map,
                                        miss_default_map_in);
          next_state.fwd_override = state.ucast_en;
        end
        uffc_pkg::UFFC_CLS_MCAST:
        begin
          next_state.fwd_map = pick_map(state.mcast_en, state.mcast_map,
                                        miss_default_map_in);
          next_state.fwd_override = state.mcast_en;
        end
        uffc_pkg::UFFC_CLS_IPMC:
        begin
          next_state.fwd_map = pick_map(state.ipmc_en, state.ipmc_map,
                                        miss_default_map_in);
          next_state.fwd_override = state.ipmc_en;
        end
        uffc_pkg::UFFC_CLS_VLAN:
        begin
          next_state.fwd_map = pick_map(state.vlan_en, state.vlan_map,
                                        miss_default_map_in);
          next_state.fwd_override = state.vlan_en;
        end
        default:
        begin
          next_state.fwd_map      = miss_default_map_in;
          next_state.fwd_override = 1'b0;
        end
      endcase
    end

    // -------------------------------------------------------
    // Egress self-address filter
    // -------------------------------------------------------
    // Self MAC may change between frames, so compare at request
    next_state.egress_valid = egress_valid_in;
    if (egress_valid_in)
    begin
      next_state.egress_drop = state.self_en && self_hit;
    end
  end

  // ---------------------------------------------------------
  // Registers
  // ---------------------------------------------------------
  // Reset names every field so no unknown reaches the maps
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state.ucast_map    <= `UFFC_RST_MAP;
      state.ucast_en     <= `UFFC_RST_EN;
      state.mcast_map    <= `UFFC_RST_MAP;
      state.mcast_en     <= `UFFC_RST_EN;
      state.vlan_map     <= `UFFC_RST_MAP;
      state.vlan_en      <= `UFFC_RST_EN;
      state.ipmc_map     <= `UFFC_RST_MAP;
      state.ipmc_en      <= `UFFC_RST_EN;
      state.self_en      <= `UFFC_RST_EN;
      state.drive        <= `UFFC_RST_DRV;
      state.strap_sync   <= {3{`UFFC_RST_STRAP}};
      state.strap_state  <= uffc_pkg::UFFC_ST_WAIT1;
      state.rdata        <= `UFFC_RD_NONE;
      state.rvalid       <= 1'b0;
      state.fwd_map      <= `UFFC_RST_MAP;
      state.fwd_override <= 1'b0;
      state.fwd_valid    <= 1'b0;
      state.egress_drop  <= 1'b0;
      state.egress_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------
  // Every output comes straight from a flop
  assign reg_rdata_out      = state.rdata;
  assign reg_rvalid_out     = state.rvalid;
  assign fwd_valid_out      = state.fwd_valid;
  assign fwd_map_out        = state.fwd_map;
  assign fwd_override_out   = state.fwd_override;
  assign egress_valid_out   = state.egress_valid;
  assign egress_drop_out    = state.egress_drop;
  assign drive_strength_out = state.drive;

endmodule // uffc_unknown_frame_forward_ctrl

// ===== include/uffc_defs.svh
// Purpose: Offsets, field positions, reset values, drive strength codes
// Assumes: 8-bit registers on the switch management port
// Notes:   Included by its bare name
`ifndef UFFC_DEFS_SVH
`define UFFC_DEFS_SVH

// -----------------------------------------------------------
// Register offsets
// -----------------------------------------------------------
`define UFFC_OFS_UCAST      8'h83
`define UFFC_OFS_DRV_MCAST  8'h84
`define UFFC_OFS_VLAN       8'h85
`define UFFC_OFS_SELF_IPMC  8'h86

// -----------------------------------------------------------
// Field positions
// -----------------------------------------------------------
`define UFFC_MAP_MSB        4
`define UFFC_EN_BIT         5
`define UFFC_SELF_BIT       6
`define UFFC_DRV_MSB        7
`define UFFC_DRV_LSB        6
`define UFFC_UCAST_B7       7

// -----------------------------------------------------------
// Reset values
// -----------------------------------------------------------
`define UFFC_RST_MAP        5'h00
`define UFFC_RST_EN         1'h0
`define UFFC_RST_DRV        2'h1
`define UFFC_RST_STRAP      1'h1
`define UFFC_UCAST_B7_VAL   1'h1
`define UFFC_RD_NONE        8'h00

// -----------------------------------------------------------
// Drive strength codes
// -----------------------------------------------------------
`define UFFC_DRV_4MA        2'h0
`define UFFC_DRV_8MA        2'h1
`define UFFC_DRV_12MA       2'h2
`define UFFC_DRV_16MA       2'h3

`endif

// ===== include/uffc_pkg.sv
// Purpose: Types of the unknown-frame forwarding control
// Assumes: Constants live in uffc_defs.svh
// Notes:   Nothing here is imported; use uffc_pkg::name
package uffc_pkg;

  // ---------------------------------------------------------
  // Lookup-miss classes
  // ---------------------------------------------------------
  typedef enum logic [1:0] {
    UFFC_CLS_UCAST = 2'h0,
    UFFC_CLS_MCAST = 2'h1,
    UFFC_CLS_IPMC  = 2'h2,
    UFFC_CLS_VLAN  = 2'h3
  } uffc_class_type;

  // ---------------------------------------------------------
  // Strap capture sequence, Gray coded
  // ---------------------------------------------------------
  typedef enum logic [1:0] {
    UFFC_ST_WAIT1 = 2'h0,
    UFFC_ST_WAIT2 = 2'h1,
    UFFC_ST_WAIT3 = 2'h3,
    UFFC_ST_RUN   = 2'h2
  } uffc_strap_state_type;

  typedef struct packed {
    logic [4:0]           ucast_map;
    logic                 ucast_en;
    logic [4:0]           mcast_map;
    logic                 mcast_en;
    logic [4:0]           vlan_map;
    logic                 vlan_en;
    logic [4:0]           ipmc_map;
    logic                 ipmc_en;
    logic                 self_en;
    logic [1:0]           drive;
    logic [2:0]           strap_sync;
    uffc_strap_state_type strap_state;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [4:0]           fwd_map;
    logic                 fwd_override;
    logic                 fwd_valid;
    logic                 egress_drop;
    logic                 egress_valid;
  } uffc_state_type;

endpackage

// ===== verif/uffc_checker_sva.sv
// Purpose: Port-level checks of the lookup-miss forwarding control
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
module uffc_checker
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        miss_valid_in,
  input wire logic [4:0]  miss_default_map_in,
  input wire logic        fwd_valid_out,
  input wire logic [4:0]  fwd_map_out,
  input wire logic        fwd_override_out,
  input wire logic        egress_valid_in,
  input wire logic [47:0] egress_mac_in,
  input wire logic [47:0] self_mac_in,
  input wire logic        egress_valid_out,
  input wire logic        egress_drop_out,
  input wire logic        drive_strength_strap_pin_in,
  input wire logic [1:0]  drive_strength_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  sequence s_rd(a); reg_rd_in && reg_addr_in == a; endsequence
  sequence s_miss_dflt; miss_valid_in ##1 !fwd_override_out; endsequence
  property p_fwd_valid; miss_valid_in |=> fwd_valid_out; endproperty
  property p_default; s_miss_dflt |-> fwd_map_out == $past(miss_default_map_in); endproperty
  property p_no_match;
    egress_valid_in && egress_mac_in != self_mac_in |=> egress_valid_out && !egress_drop_out;
  endproperty
  property p_drop_cause;
    egress_valid_out && egress_drop_out |-> $past(egress_mac_in) == $past(self_mac_in);
  endproperty
  // Strap load lands three or four edges after release; skip reads racing it
  property p_drv_rd;
    s_rd(8'h84) ##0 !reg_wr_in && !$past(rst_in, 4) |=> reg_rdata_out[7:6] == drive_strength_out;
  endproperty
  property p_strap;
    $fell(rst_in) |-> ##4 drive_strength_out == {~drive_strength_strap_pin_in, drive_strength_strap_pin_in};
  endproperty
  property p_83_rsvd; s_rd(8'h83) |=> reg_rdata_out[7:6] == 2'h2; endproperty
  property p_85_rsvd; s_rd(8'h85) |=> reg_rdata_out[7:6] == 2'h0; endproperty
  property p_86_rsvd; s_rd(8'h86) |=> !reg_rdata_out[7]; endproperty
  a_fwd_valid: assert property (p_fwd_valid) else $error("no forward answer");
  a_default: assert property (p_default) else $error("default map not used");
  a_no_match: assert property (p_no_match) else $error("drop without match");
  a_drop_cause: assert property (p_drop_cause) else $error("drop cause wrong");
  a_drv_rd: assert property (p_drv_rd) else $error("drive readback differs");
  a_strap: assert property (p_strap) else $error("strap load wrong");
  a_83_rsvd: assert property (p_83_rsvd) else $error("fixed bits wrong");
  a_85_rsvd: assert property (p_85_rsvd) else $error("fixed bits wrong");
  a_86_rsvd: assert property (p_86_rsvd) else $error("fixed bit wrong");
endmodule // uffc_checker

bind uffc_unknown_frame_forward_ctrl uffc_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .miss_valid_in(miss_valid_in), .miss_default_map_in(miss_default_map_in), .fwd_valid_out(fwd_valid_out),
  .fwd_map_out(fwd_map_out), .fwd_override_out(fwd_override_out), .egress_valid_in(egress_valid_in),
  .egress_mac_in(egress_mac_in), .self_mac_in(self_mac_in), .egress_valid_out(egress_valid_out),
  .egress_drop_out(egress_drop_out), .drive_strength_strap_pin_in(drive_strength_strap_pin_in),
  .drive_strength_out(drive_strength_out));

// ===== verif/tb.sv
// Purpose: Self-checking bench of the lookup-miss forwarding control
// Assumes: Strobe register port, one 50 MHz clock
// Notes:   Second reset reloads the drive strap
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk_in = 1'b0;
  logic                     rst_in = 1'b1;
  logic [7:0]               reg_addr_in = 8'h00;
  logic                     reg_wr_in = 1'b0;
  logic [7:0]               reg_wdata_in = 8'h00;
  logic                     reg_rd_in = 1'b0;
  logic [7:0]               reg_rdata_out;
  logic                     reg_rvalid_out;
  logic                     miss_valid_in = 1'b0;
  uffc_pkg::uffc_class_type miss_class_in = uffc_pkg::UFFC_CLS_UCAST;
  logic [4:0]               miss_default_map_in = 5'h15;
  logic                     fwd_valid_out;
  logic [4:0]               fwd_map_out;
  logic                     fwd_override_out;
  logic                     egress_valid_in = 1'b0;
  logic [47:0]              egress_mac_in = 48'h0;
  logic [47:0]              self_mac_in = 48'h02a0_c0de_0001;
  logic                     egress_valid_out;
  logic                     egress_drop_out;
  logic                     drive_strength_strap_pin_in = 1'b1;
  logic [1:0]               drive_strength_out;
  int                       n_fail = 0;
  int                       cmp_count = 0;
  // Register offsets and high bits read after reset, indexed by class code
  localparam logic [7:0] adr_t [4] = '{8'h83, 8'h84, 8'h86, 8'h85};
  localparam logic [7:0] hi_t [4] = '{8'h80, 8'h40, 8'h00, 8'h00};
  localparam logic [7:0] ff_t [4] = '{8'hbf, 8'hff, 8'h7f, 8'h3f};
  localparam logic [4:0] map_t [4] = '{5'h00, 5'h03, 5'h1f, 5'h01};

  always #10 clk_in = ~clk_in;

  uffc_unknown_frame_forward_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .miss_valid_in(miss_valid_in), .miss_class_in(miss_class_in),
    .miss_default_map_in(miss_default_map_in), .fwd_valid_out(fwd_valid_out), .fwd_map_out(fwd_map_out),
    .fwd_override_out(fwd_override_out), .egress_valid_in(egress_valid_in), .egress_mac_in(egress_mac_in),
    .self_mac_in(self_mac_in), .egress_valid_out(egress_valid_out), .egress_drop_out(egress_drop_out),
    .drive_strength_strap_pin_in(drive_strength_strap_pin_in), .drive_strength_out(drive_strength_out));

  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rvalid_out, 8'h01);
    chk(reg_rdata_out, exp);
  endtask
  task automatic miss(input int c, input logic [4:0] m, input logic ovr);
    @(posedge clk_in);
    miss_valid_in <= 1'b1;
    miss_class_in <= uffc_pkg::uffc_class_type'(c[1:0]);
    @(posedge clk_in);
    miss_valid_in <= 1'b0;
    #1;
    chk(fwd_valid_out, 8'h01);
    chk(fwd_map_out, m);
    chk(fwd_override_out, ovr);
  endtask
  task automatic egr(input logic [47:0] mac, input logic drop);
    @(posedge clk_in);
    egress_valid_in <= 1'b1;
    egress_mac_in <= mac;
    @(posedge clk_in);
    egress_valid_in <= 1'b0;
    #1;
    chk(egress_valid_out, 8'h01);
    chk(egress_drop_out, drop);
  endtask
  task automatic rst_cycle(input logic p);
    @(posedge clk_in);
    drive_strength_strap_pin_in <= p;
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    chk(drive_strength_out, {~p, p});
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    logic [7:0] d;
    rst_cycle(1'b1);
    for (int c = 0; c < 4; c++)
      rd(adr_t[c], hi_t[c]);
    rd(8'h82, 8'h00);
    // Every class, every map boundary, enabled then disabled
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 8; i++)
      begin
        d = hi_t[c] | {2'h0, ~i[0], map_t[i[2:1]]};
        wr(adr_t[c], d);
        rd(adr_t[c], d);
        miss(c, d[5] ? d[4:0] : miss_default_map_in, d[5]);
      end
    for (int c = 0; c < 4; c++)
    begin
      wr(adr_t[c], 8'hff);
      rd(adr_t[c], ff_t[c]);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h84, {k[1:0], 6'h00});
      #1;
      chk(drive_strength_out, k[7:0]);
    end
    wr(8'h86, 8'h00);
    egr(self_mac_in, 1'b0);
    wr(8'h86, 8'h40);
    egr(self_mac_in, 1'b1);
    egr(self_mac_in ^ 48'h1, 1'b0);
    egr(self_mac_in ^ 48'h8000_0000_0000, 1'b0);
    wr(8'h87, 8'hff);
    rd(8'h87, 8'h00);
    rd(8'h86, 8'h40);
    rst_cycle(1'b0);
    rd(8'h84, 8'h80);
    miss(3, miss_default_map_in, 1'b0);
    tally_and_finish();
  end

  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule // tb
